// File: design/dual_serial_host_port.v
// auto-detecting SPI / I2C host port of the DAC
`timescale 1ns/1ps
`include "dual_serial_host_port_defs.vh"
module dual_serial_host_port (
  // clock and power-on reset
  input  wire        clock,
  input  wire        rst,
  // spi pins
  input  wire        frame_sel_n,
  input  wire        spi_clk,
  input  wire        spi_din,
  output reg         spi_dout,
  output reg         spi_dout_oe,
  // i2c pins, open drain data
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        addr_select_pin,
  // configuration levels
  input  wire        gpio_is_sdo,
  input  wire        serial_out_enable,
  input  wire        out_edge_select,
  // register side
  output reg         reg_wr,
  output reg  [7:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  output reg  [7:0]  rd_addr,
  input  wire [15:0] readback_word,
  // status
  output reg         spi_mode,
  output reg         i2c_mode,
  output reg         soft_reset
);

  // two-flop synchronisers for every pin
  reg [1:0] cs_sync, sck_sync, din_sync, scl_sync, sda_sync, apin_sync;
  reg       cs_prev, sck_prev, scl_prev, sda_prev;

  // spi state
  reg [23:0] in_sr;
  reg [23:0] out_sr;
  reg [4:0]  edge_mod;
  reg        seen_full;
  reg        last_din;
  reg        rd_pend;
  reg [7:0]  echo_cmd;

  // i2c state
  reg [3:0]  i_bit;
  reg [1:0]  i_byte;
  reg [7:0]  i_sr;
  reg [7:0]  i_cmd;
  reg [7:0]  i_msb;
  reg [15:0] tx_sr;
  reg        i_act, i_rd, i_tx, i_gc, i_ackph;
  reg        a_hi, a_lo, a_nsda, a_nscl;

  // decoded edges and conditions
  wire cs_n     = cs_sync[1];
  wire sck_fall = sck_prev & ~sck_sync[1];
  wire sck_rise = ~sck_prev & sck_sync[1];
  wire scl_rise = ~scl_prev & scl_sync[1];
  wire scl_fall = scl_prev & ~scl_sync[1];
  wire i_start  = scl_prev & scl_sync[1] & sda_prev & ~sda_sync[1];
  wire i_stop   = scl_prev & scl_sync[1] & ~sda_prev & sda_sync[1];
  wire sdo_on   = gpio_is_sdo & serial_out_enable;
  wire four_wire = sdo_on;

  // low address bits from what the address-select pin tracked
  function [2:0] pin_code;
    input hi, lo, nsda;
    begin
      if (!hi)
        pin_code = 3'h0;
      else if (!lo)
        pin_code = 3'h1;
      else if (!nsda)
        pin_code = 3'h2;
      else
        pin_code = 3'h3;
    end
  endfunction

  wire [2:0] my_low  = pin_code(a_hi, a_lo, a_nsda);
  wire       hit_own = (i_sr[7:1] == {`I2C_ADDR_UPPER, my_low});
  wire       hit_gc  = (i_sr == `I2C_GCALL_BYTE);
  wire       hit_bc  = (i_sr[7:1] == `I2C_BCAST_ADDR) & ~i_sr[0];

  // frame acceptance at frame-select rising
  wire spi_ok3 = seen_full;
  wire spi_ok4 = seen_full & (edge_mod == 5'h00);

  // pin synchronisers, first flop feeds only the second
  always @(posedge clock) begin
    if (rst) begin
      cs_sync   <= 2'h3;
      sck_sync  <= 2'h0;
      din_sync  <= 2'h0;
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      apin_sync <= 2'h0;
      cs_prev   <= 1'b1;
      sck_prev  <= 1'b0;
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
    end else begin
      cs_sync   <= {cs_sync[0], frame_sel_n};
      sck_sync  <= {sck_sync[0], spi_clk};
      din_sync  <= {din_sync[0], spi_din};
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      apin_sync <= {apin_sync[0], addr_select_pin};
      cs_prev   <= cs_sync[1];
      sck_prev  <= sck_sync[1];
      scl_prev  <= scl_sync[1];
      sda_prev  <= sda_sync[1];
    end
  end

  // interface detection, cleared only by power-on reset
  always @(posedge clock) begin
    if (rst) begin
      spi_mode <= 1'b0;
      i2c_mode <= 1'b0;
    end else if (!spi_mode && !i2c_mode) begin
      if (cs_prev && !cs_n)
        spi_mode <= 1'b1;
      else if (i_start)
        i2c_mode <= 1'b1;
    end
  end

  // spi engine; idle unless spi was detected first
  always @(posedge clock) begin
    if (rst) begin
      in_sr       <= 24'h000000;
      out_sr      <= 24'h000000;
      edge_mod    <= 5'h00;
      seen_full   <= 1'b0;
      last_din    <= 1'b0;
      spi_dout    <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else begin
      // output only inside a frame, only when mapped and enabled
      spi_dout_oe <= spi_mode & ~cs_n & sdo_on;
      if (rd_pend) begin
        // readback word arrives one cycle after its address goes out
        out_sr  <= {echo_cmd, readback_word};
      end
      if (spi_mode && cs_n) begin
        // clock and data blocked between frames
        edge_mod <= 5'h00;
        seen_full <= 1'b0;
        spi_dout <= out_sr[23];
      end else if (spi_mode) begin
        if (sck_fall) begin
          last_din <= din_sync[1];
          // three-wire keeps first 24 bits, four-wire the latest 24
          if (four_wire || !seen_full)
            in_sr <= {in_sr[22:0], din_sync[1]};
          if (edge_mod == 5'd23) begin
            edge_mod  <= 5'h00;
            seen_full <= 1'b1;
          end else begin
            edge_mod <= edge_mod + 5'h01;
          end
        end
        // launch edge chosen by edge select; rising waits for a falling first
        if ((!out_edge_select && sck_fall) ||
            (out_edge_select && sck_rise && (seen_full || edge_mod != 5'h00))) begin
          out_sr   <= {out_sr[22:0], out_edge_select ? last_din : din_sync[1]};
          spi_dout <= out_sr[22];
        end
      end
    end
  end

  // link logic, register strobes and i2c engine
  always @(posedge clock) begin
    if (rst) begin
      reg_wr     <= 1'b0;
      reg_addr   <= 8'h00;
      reg_wdata  <= 16'h0000;
      rd_addr    <= 8'h00;
      soft_reset <= 1'b0;
      rd_pend    <= 1'b0;
      echo_cmd   <= 8'h00;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      i_bit      <= 4'h0;
      i_byte     <= 2'h0;
      i_sr       <= 8'h00;
      i_cmd      <= 8'h00;
      i_msb      <= 8'h00;
      tx_sr      <= 16'h0000;
      i_act      <= 1'b0;
      i_rd       <= 1'b0;
      i_tx       <= 1'b0;
      i_gc       <= 1'b0;
      i_ackph    <= 1'b0;
      a_hi       <= 1'b0;
      a_lo       <= 1'b0;
      a_nsda     <= 1'b0;
      a_nscl     <= 1'b0;
    end else begin
      reg_wr     <= 1'b0;
      soft_reset <= 1'b0;
      // readback load request lives here only, so it has a single driver
      rd_pend    <= 1'b0;
      // spi frame end: accept, then write or arm readback
      if (spi_mode && !cs_prev && cs_n && (four_wire ? spi_ok4 : spi_ok3)) begin
        if (in_sr[`SPI_RW_BIT]) begin
          rd_addr  <= {1'b0, in_sr[`SPI_ADDR_HI:`SPI_ADDR_LO]};
          echo_cmd <= in_sr[23:16];
          rd_pend  <= 1'b1;
        end else begin
          reg_wr    <= 1'b1;
          reg_addr  <= {1'b0, in_sr[`SPI_ADDR_HI:`SPI_ADDR_LO]};
          reg_wdata <= in_sr[15:0];
        end
      end
      if (!i2c_mode && !(i_start && !spi_mode)) begin
        // spi owns the port or neither interface is detected yet; i2c stays released
        sda_oe <= 1'b0;
      end else if (i_start) begin
        // start or repeated start restarts byte framing
        i_bit   <= 4'h0;
        i_byte  <= 2'h0;
        i_act   <= 1'b0;
        i_tx    <= 1'b0;
        i_gc    <= 1'b0;
        i_ackph <= 1'b0;
        sda_oe  <= 1'b0;
        a_hi    <= 1'b0;
        a_lo    <= 1'b0;
        a_nsda  <= 1'b0;
        a_nscl  <= 1'b0;
      end else if (i_stop) begin
        // controller ends the transfer; bus released
        i_act   <= 1'b0;
        i_tx    <= 1'b0;
        i_bit   <= 4'h0;
        i_ackph <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        // track the address pin through the first byte
        if (i_byte == 2'h0 && i_bit != 4'h8) begin
          a_hi   <= a_hi | apin_sync[1];
          a_lo   <= a_lo | ~apin_sync[1];
          a_nsda <= a_nsda | (apin_sync[1] ^ sda_sync[1]);
          a_nscl <= a_nscl | (apin_sync[1] ^ scl_sync[1]);
        end
        if (scl_rise) begin
          if (i_bit != 4'h8) begin
            i_sr  <= {i_sr[6:0], sda_sync[1]};
            i_bit <= i_bit + 4'h1;
          end else if (i_tx && sda_sync[1]) begin
            // controller not-acknowledge ends the read
            i_tx  <= 1'b0;
            i_act <= 1'b0;
          end else if (i_gc && i_byte == 2'h1 && i_sr == `I2C_GCALL_RESET) begin
            soft_reset <= 1'b1;
          end
        end
        if (scl_fall) begin
          if (i_bit == 4'h8 && !i_ackph) begin
            // end of a byte: decide on the acknowledge
            i_ackph <= 1'b1;
            sda_oe  <= 1'b0;
            if (i_byte == 2'h0) begin
              i_act  <= hit_own | hit_gc | hit_bc;
              i_rd   <= hit_own & i_sr[0];
              i_gc   <= hit_gc;
              sda_oe <= hit_own | hit_gc | hit_bc;
            end else if (i_act && !i_tx) begin
              sda_oe <= 1'b1;
              if (i_byte == 2'h1) begin
                i_cmd   <= i_sr;
                rd_addr <= i_sr;
              end
              if (i_byte == 2'h2)
                i_msb <= i_sr;
            end
          end else if (i_bit == 4'h8) begin
            // falling edge closing the ack bit
            i_ackph <= 1'b0;
            i_bit   <= 4'h0;
            sda_oe  <= 1'b0;
            if (i_byte != `I2C_LAST_BYTE)
              i_byte <= i_byte + 2'h1;
            if (i_act && i_rd && i_byte == 2'h0) begin
              i_tx   <= 1'b1;
              tx_sr  <= readback_word;
              sda_oe <= ~readback_word[15];
            end else if (i_tx) begin
              tx_sr  <= {tx_sr[14:0], 1'b0};
              sda_oe <= ~tx_sr[14];
            end
            if (i_act && !i_tx && !i_rd && !i_gc && i_byte == `I2C_LAST_BYTE) begin
              reg_wr    <= 1'b1;
              reg_addr  <= i_cmd;
              reg_wdata <= {i_msb, i_sr};
            end
          end else if (i_tx) begin
            // next data bit while transmitting
            tx_sr  <= {tx_sr[14:0], 1'b0};
            sda_oe <= ~tx_sr[14];
          end
        end
      end
    end
  end

endmodule // dual_serial_host_port

// File: design/dual_serial_host_port_defs.vh
// constants for the dual serial host port
// What this block does
// - first protocol to talk after power-up wins; later switch attempts ignored.
// - SPI cycle runs from frame-select falling to frame-select rising.
// - input bits sampled on SPI clock falling edges; free or gated clock.
// - frame is 24 bits; cycles with fewer falling edges are discarded.
// - three-wire cycles longer than 24 edges use only the first 24 bits.
// - frame-select high blocks clock and data, serial output released.
// - first byte holds read flag and 7-bit address; last 16 bits data.
// - serial output off after reset; on when pin mapped and enable set.
// - read is two frames; second returns flag, address, then data word.
// - serial output launched on falling or rising edge per edge select.
// - four-wire cycles of 24-multiple edges use last 24 bits, else ignored.
// - I2C target only, 7-bit addresses, no 10-bit response.
// - standard, fast and fast-plus rates, same protocol.
// - receiver acknowledges by holding data low through ninth clock high phase.
// - general call 0x00 then 0x06 resets, at ack rising edge of second byte.
// - target address 1001 plus three bits from how the address-select pin is tied (low, high, to SDA, other).
// - I2C write is address, command, MSB, LSB; update at last ack falling.
`ifndef DUAL_SERIAL_HOST_PORT_DEFS_VH
`define DUAL_SERIAL_HOST_PORT_DEFS_VH
`define SPI_FRAME_BITS   24
`define SPI_RW_BIT       23
`define SPI_ADDR_HI      22
`define SPI_ADDR_LO      16
`define I2C_ADDR_UPPER   4'h9
`define I2C_BCAST_ADDR   7'h47
`define I2C_GCALL_BYTE   8'h00
`define I2C_GCALL_RESET  8'h06
`define I2C_LAST_BYTE    2'h3
`define SYNC_STAGES      2
`endif

// File: test/dual_serial_host_port_bench.sv
// self-checking bench for the dual serial host port
`timescale 1ns/1ps
module dual_serial_host_port_bench;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         gpio_is_sdo = 1'b0;
  reg         serial_out_enable = 1'b0;
  reg         out_edge_select = 1'b0;
  reg         addr_select_pin = 1'b0;
  wire        frame_sel_n, spi_clk, spi_din, spi_dout, spi_dout_oe, scl_in, sda_in, sda_out, sda_oe;
  wire        reg_wr, spi_mode, i2c_mode, soft_reset;
  wire [7:0]  reg_addr, rd_addr;
  wire [15:0] reg_wdata;
  wire [15:0] readback_word = {rd_addr, ~rd_addr};
  integer     err_count = 0, check_count = 0, wr_n = 0, sr_n = 0, n0;
  reg  [71:0] got;
  reg         a0, a1, a2, a3;
  dual_serial_host_port dut_u (.clock, .rst, .frame_sel_n, .spi_clk, .spi_din, .spi_dout, .spi_dout_oe,
    .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_pin, .gpio_is_sdo, .serial_out_enable,
    .out_edge_select, .reg_wr, .reg_addr, .reg_wdata, .rd_addr, .readback_word, .spi_mode, .i2c_mode, .soft_reset);
  serial_host_model host_u (.clock, .frame_sel_n, .spi_clk, .spi_din, .spi_dout, .out_edge_select,
    .scl_in, .sda_in, .sda_oe);
  initial forever #5 clock = ~clock;
  // count pulses so late or doubled ones show up
  always @(posedge clock) begin
    if (reg_wr === 1'b1) wr_n <= wr_n + 1;
    if (soft_reset === 1'b1) sr_n <= sr_n + 1;
  end
  task chk(input c, input string m);
    begin
      check_count = check_count + 1;
      if (!c) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: %s", $time, m);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task spi(input [71:0] b, input integer n);
    begin
      n0 = wr_n;
      host_u.spi_frame(b, n, got);
    end
  endtask
  task t_spi_basic;
    begin
      spi(72'h15A5C3, 24);
      chk(wr_n === n0 + 1 && reg_addr === 8'h15 && reg_wdata === 16'hA5C3, "spi write");
      chk(spi_mode === 1'b1 && i2c_mode === 1'b0, "spi not detected");
      spi(72'h15FFFF, 23);
      chk(wr_n === n0, "short frame taken");
      spi({24'h2B1234, 6'h3F}, 30);
      chk(wr_n === n0 + 1 && reg_addr === 8'h2B && reg_wdata === 16'h1234, "long frame");
    end
  endtask
  task t_daisy;
    begin
      gpio_is_sdo = 1'b1;
      serial_out_enable = 1'b1;
      spi({24'h33BEEF, 24'h070102}, 48);
      chk(wr_n === n0 + 1 && reg_addr === 8'h07 && reg_wdata === 16'h0102, "chain frame");
      spi(72'h0, 40);
      chk(wr_n === n0, "odd chain taken");
    end
  endtask
  // readback paced slower than writes
  task t_read(input e);
    begin
      out_edge_select = e;
      host_u.half = 8;
      spi(72'hAA0000, 24);
      chk(rd_addr === 8'h2A, "read address");
      spi(72'hAA0000, 24);
      chk(got[23:0] === 24'hAA2AD5, "readback word");
      host_u.half = 4;
    end
  endtask
  task t_i2c;
    begin
      n0 = wr_n;
      host_u.i2c_start;
      host_u.i2c_byte(8'h90, a0);
      host_u.i2c_byte(8'h21, a1);
      host_u.i2c_byte(8'h12, a2);
      host_u.i2c_byte(8'h34, a3);
      host_u.i2c_stop;
    end
  endtask
  task t_i2c_misc;
    begin
      host_u.i2c_start;
      host_u.i2c_byte(8'h92, a0);
      host_u.i2c_stop;
      host_u.i2c_start;
      host_u.i2c_byte(8'hF0, a1);
      host_u.i2c_stop;
      chk(a0 === 1'b0, "foreign address acked");
      chk(a1 === 1'b0, "ten-bit header acked");
      n0 = sr_n;
      host_u.i2c_start;
      host_u.i2c_byte(8'h00, a0);
      host_u.i2c_byte(8'h06, a1);
      host_u.i2c_stop;
      chk((a0 & a1) === 1'b1 && sr_n === n0 + 1, "general call reset");
    end
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    t_spi_basic;
    t_daisy;
    t_read(1'b0);
    t_read(1'b1);
    t_i2c;
    chk(a0 === 1'b0 && wr_n === n0, "i2c taken in spi mode");
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    chk(spi_mode === 1'b0 && i2c_mode === 1'b0, "detection kept");
    t_i2c;
    chk((a0 & a1 & a2 & a3) === 1'b1, "i2c acks");
    chk(wr_n === n0 + 1 && reg_addr === 8'h21 && reg_wdata === 16'h1234, "i2c write");
    spi(72'h15A5C3, 24);
    chk(wr_n === n0 && i2c_mode === 1'b1, "spi taken in i2c mode");
    t_i2c_misc;
    conclude;
  end
  // cut a hang short
  initial begin
    #1000000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // dual_serial_host_port_bench

// File: test/dual_serial_host_port_checker.sv
// pin-level assertions for the dual serial host port
`timescale 1ns/1ps
module dual_serial_host_port_checker (
  // clock and reset
  input wire clock,
  input wire rst,
  // watched pins
  input wire frame_sel_n,
  input wire spi_dout_oe,
  input wire gpio_is_sdo,
  input wire serial_out_enable,
  input wire sda_out,
  input wire sda_oe,
  input wire reg_wr,
  input wire spi_mode,
  input wire i2c_mode,
  input wire soft_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_one_mode: assert property (!(spi_mode && i2c_mode)) else $error("both modes set");
  a_spi_locked: assert property (spi_mode |=> spi_mode) else $error("spi mode lost");
  a_i2c_locked: assert property (i2c_mode |=> i2c_mode) else $error("i2c mode lost");
  a_no_ack_spi: assert property (spi_mode |-> !sda_oe) else $error("sda pulled in spi mode");
  a_idle_quiet: assert property (frame_sel_n [*4] |-> !spi_dout_oe) else $error("sdo driven idle");
  a_oe_config: assert property ((!(gpio_is_sdo && serial_out_enable)) [*2] |-> !spi_dout_oe) else $error("sdo on");
  a_oe_spi_only: assert property (spi_dout_oe |-> spi_mode) else $error("sdo outside spi");
  a_wr_pulse: assert property (reg_wr |=> !reg_wr) else $error("write pulse too long");
  a_wr_framed: assert property (reg_wr && spi_mode |-> $past(frame_sel_n, 2)) else $error("write in frame");
  a_reset_call: assert property (soft_reset |-> i2c_mode && !$past(soft_reset)) else $error("bad soft reset");
  a_sda_drain: assert property (sda_oe |-> !sda_out) else $error("sda not low");
  // main scenarios reached
  c_spi_wr: cover property (reg_wr && spi_mode);
  c_i2c_wr: cover property (reg_wr && i2c_mode);
  c_soft: cover property (soft_reset);
  c_sdo: cover property (spi_dout_oe);
endmodule // dual_serial_host_port_checker
bind dual_serial_host_port dual_serial_host_port_checker chk_u (.clock, .rst, .frame_sel_n, .spi_dout_oe,
  .gpio_is_sdo, .serial_out_enable, .sda_out, .sda_oe, .reg_wr, .spi_mode, .i2c_mode, .soft_reset);

// File: test/serial_host_model.sv
// spi host and i2c controller driving the port's pins
`timescale 1ns/1ps
module serial_host_model (
  // pacing clock
  input  wire clock,
  // spi pins
  output reg  frame_sel_n = 1'b1,
  output reg  spi_clk = 1'b0,
  output reg  spi_din = 1'b0,
  input  wire spi_dout,
  input  wire out_edge_select,
  // i2c pins
  output reg  scl_in = 1'b1,
  output wire sda_in,
  input  wire sda_oe
);
  integer half = 4;
  reg     sda_low = 1'b0;
  // open-drain data line with pull-up
  assign sda_in = ~(sda_low | sda_oe);
  task q(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // gated clock idles low so no stray falls outside frames
  task spi_frame(input [71:0] b, input integer n, output [71:0] got);
    integer i;
    begin
      got = 72'h0;
      frame_sel_n = 1'b0;
      q(8);
      for (i = n - 1; i >= 0; i = i - 1) begin
        if (!out_edge_select) got[i] = spi_dout;
        spi_clk = 1'b1;
        spi_din = b[i];
        q(half);
        if (out_edge_select) got[i] = spi_dout;
        spi_clk = 1'b0;
        q(half);
      end
      frame_sel_n = 1'b1;
      spi_din = ~spi_din;
      q(16);
    end
  endtask
  // one bit, clock made here, data moved only while low
  task i2c_bit(input d, output r);
    begin
      sda_low = ~d;
      q(25);
      scl_in = 1'b1;
      q(25);
      r = sda_in;
      q(25);
      scl_in = 1'b0;
      q(25);
    end
  endtask
  task i2c_start;
    begin
      sda_low = 1'b1;
      q(25);
      scl_in = 1'b0;
      q(25);
    end
  endtask
  task i2c_byte(input [7:0] b, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) i2c_bit(b[i], r);
      i2c_bit(1'b1, r);
      ack = ~r;
    end
  endtask
  task i2c_stop;
    begin
      sda_low = 1'b1;
      q(25);
      scl_in = 1'b1;
      q(25);
      sda_low = 1'b0;
      q(100);
    end
  endtask
endmodule // serial_host_model
